// >>> design/sscr_pkg.sv
/*
 Package for the system state and energy reserve control block:
 register offsets, field positions, reset values, timing counts, state
 enumerations and the port carrier structs.
 It assumes one 100 MHz clock and a plain register port with read data one cycle late.
*/
package sscr_pkg;
   // Register offsets
   localparam logic [7:0] SYSTEM_CONTROL_REG_ADDR = 8'h00;
   localparam logic [7:0] SYSTEM_CONFIG_REG_ADDR  = 8'h04;
   localparam logic [7:0] STATE_CMD_ADDR          = 8'h08;
   localparam logic [7:0] TEST_CMD_ADDR           = 8'h0c;
   localparam logic [7:0] SAFING_RECORD_ADDR      = 8'h10;
   localparam logic [7:0] DEPLOY_MASK_ADDR        = 8'h14;
   localparam logic [7:0] POWER_STATE_ADDR        = 8'h18;
   localparam logic [7:0] FAULT_STATUS_REG_ADDR   = 8'h1c;
   localparam logic [7:0] WDG_WINDOW_ADDR         = 8'h20;
   // Control field positions
   localparam int CTL_BOOST_EN_BIT  = 0;
   localparam int CTL_BOOST_HI_BIT  = 1;
   localparam int CTL_CHARGE_EN_BIT = 2;
   localparam int CFG_HOLD_BIT      = 0;
   // Reset values: boost enabled at the low setting
   localparam logic [2:0] CTL_RESET   = 3'h1;
   localparam logic       CFG_RESET   = 1'b0;
   localparam logic [7:0] WDG_RESET   = 8'h00;
   // State command codes
   localparam logic [1:0] CMD_SAFING = 2'h1;
   localparam logic [1:0] CMD_SCRAP  = 2'h2;
   localparam logic [1:0] CMD_ARMING = 2'h3;
   // Test command codes, one active at a time
   localparam logic [1:0] TEST_NONE    = 2'h0;
   localparam logic [1:0] TEST_HS_SW   = 2'h1;
   localparam logic [1:0] TEST_LS_SW   = 2'h2;
   localparam logic [1:0] TEST_SF_FET  = 2'h3;
   localparam int         TEST_LEN_CYC = 64;
   // Timing
   localparam int EARLY_WAKE_MS   = 9;
   localparam int CLK_MHZ         = 100;
   localparam int EARLY_WAKE_CYC  = EARLY_WAKE_MS * 1000 * CLK_MHZ;
   localparam int ARMING_TIMEOUT_US  = 100;
   localparam int ARMING_TIMEOUT_CYC = ARMING_TIMEOUT_US * CLK_MHZ;

   typedef enum logic [2:0] {
      OP_INIT   = 3'b000,
      OP_DIAG   = 3'b001,
      OP_SAFING = 3'b010,
      OP_SCRAP  = 3'b011,
      OP_ARMING = 3'b100
   } sscr_op_type;

   typedef enum logic [1:0] {
      PM_ACTIVE  = 2'b00,
      PM_PASSIVE = 2'b01,
      PM_SLEEP   = 2'b10
   } sscr_pm_type;

   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } sscr_bus_type;

   // Analog and system status inputs
   typedef struct packed {
      logic wake;
      logic supply_low;
      logic battery_lost;
      logic boost_undervolt;
      logic boost_overtemp;
      logic ground_lost;
      logic por;
      logic wdg_reset;
      logic wdg_fail;
      logic wdg_service_ok;
      logic extra_line_check;
      logic arm_pin_stuck;
      logic fire_time_bad;
   } sscr_stat_type;

   // Control outputs
   typedef struct packed {
      logic boost_switch_on;
      logic boost_high_sel;
      logic charge_gen_on;
      logic crossover_active_out;
      logic reserve_switch_on;
      logic arm_out;
      logic safing_active;
      logic remote_monitor_on;
      logic [1:0] test_run;
      logic sleep_req;
   } sscr_ctl_type;
endpackage

// >>> design/sscr_top.sv
/*
 System operating state machine and energy reserve digital control.
 Assumes all status inputs are synchronous to REF_CLK and that the
 host keeps strobes one cycle long and never both at once.
*/
`timescale 1ns/10ps
module sscr_top #(
   parameter int EARLY_WAKE_CYCLES = sscr_pkg::EARLY_WAKE_CYC,
   parameter int ARM_TIMEOUT_CYCLES = sscr_pkg::ARMING_TIMEOUT_CYC
) (
   input  wire logic                   REF_CLK,
   input  wire logic                   RST,
   input  wire sscr_pkg::sscr_bus_type BUS,
   output logic [15:0]                 RDATA,
   input  wire sscr_pkg::sscr_stat_type STAT,
   output sscr_pkg::sscr_ctl_type      CTL,
   output sscr_pkg::sscr_op_type       OP_STATE,
   output sscr_pkg::sscr_pm_type       POWER_MODE
);
   import sscr_pkg::*;

   typedef struct packed {
      sscr_op_type op;
      sscr_pm_type pm;
      logic [2:0]  ctl;
      logic        cfg;
      logic [7:0]  wdg_win;
      logic [15:0] safing_rec;
      logic [15:0] deploy_mask;
      logic        ot_latch;
      logic        rst_cause;
      logic        wake_seen_low;
      logic [31:0] early_cnt;
      logic [31:0] arm_cnt;
      logic [1:0]  test;
      logic [6:0]  test_cnt;
      logic        arm_stuck;
      logic        fire_bad;
      logic [15:0] rdata;
   } sscr_state_type;

   sscr_state_type s_q;
   sscr_state_type s_d;
   logic           ssm_rst;
   logic           active;
   logic           early;
   logic [1:0]     cmd;

   // State machine reset sources
   assign ssm_rst = STAT.por | STAT.wdg_reset | STAT.wdg_fail;
   assign active  = (s_q.pm == PM_ACTIVE);
   assign early   = (s_q.early_cnt < 32'(EARLY_WAKE_CYCLES));
   assign cmd     = BUS.wdata[1:0];

   // Next state
   always_comb begin
      s_d = s_q;
      // Power mode handling
      if (s_q.pm == PM_ACTIVE) begin
         if (early) begin
            s_d.early_cnt = s_q.early_cnt + 32'h1;
         end
         if (STAT.supply_low) begin
            s_d.pm = PM_PASSIVE;
         end else if (!STAT.wake && early) begin
            s_d.pm = PM_SLEEP;
         end else if (BUS.wr && BUS.addr == STATE_CMD_ADDR && BUS.wdata[15] &&
                      !STAT.wake && !early) begin
            s_d.pm = PM_PASSIVE;
         end
      end
      // Operating state machine
      case (s_q.op)
         OP_INIT: begin
            if (STAT.wdg_service_ok) begin
               s_d.op = OP_DIAG;
            end
         end
         OP_DIAG: begin
            if (BUS.wr && BUS.addr == STATE_CMD_ADDR && cmd == CMD_SAFING) begin
               s_d.op = OP_SAFING;
            end else if (BUS.wr && BUS.addr == STATE_CMD_ADDR && cmd == CMD_SCRAP) begin
               s_d.op = OP_SCRAP;
            end
         end
         OP_SAFING: begin
            s_d.op = OP_SAFING;
         end
         OP_SCRAP: begin
            if (BUS.wr && BUS.addr == STATE_CMD_ADDR && cmd == CMD_ARMING) begin
               s_d.op      = OP_ARMING;
               s_d.arm_cnt = 32'h0;
            end
         end
         OP_ARMING: begin
            if (STAT.extra_line_check) begin
               s_d.arm_cnt = 32'h0;
            end else if (s_q.arm_cnt >= 32'(ARM_TIMEOUT_CYCLES - 1)) begin
               s_d.op = OP_SCRAP;
            end else begin
               s_d.arm_cnt = s_q.arm_cnt + 32'h1;
            end
         end
         default: begin
            s_d.op = OP_INIT;
         end
      endcase
      // Register writes
      if (BUS.wr) begin
         case (BUS.addr)
            SYSTEM_CONTROL_REG_ADDR: s_d.ctl = BUS.wdata[2:0];
            SYSTEM_CONFIG_REG_ADDR:  s_d.cfg = BUS.wdata[CFG_HOLD_BIT];
            WDG_WINDOW_ADDR: begin
               if (s_q.op == OP_INIT) begin
                  s_d.wdg_win = BUS.wdata[7:0];
               end
            end
            SAFING_RECORD_ADDR: begin
               if (s_q.op == OP_DIAG) begin
                  s_d.safing_rec = BUS.wdata;
               end
            end
            DEPLOY_MASK_ADDR: begin
               if (s_q.op == OP_DIAG) begin
                  s_d.deploy_mask = BUS.wdata;
               end
            end
            TEST_CMD_ADDR: begin
               if (s_q.op == OP_DIAG && s_q.test == TEST_NONE) begin
                  s_d.test     = BUS.wdata[1:0];
                  s_d.test_cnt = 7'h0;
               end
            end
            default: begin
            end
         endcase
      end
      // Test sequencing, aborted outside Diag
      if (s_q.test != TEST_NONE) begin
         s_d.test_cnt = s_q.test_cnt + 7'h1;
         if (s_q.op != OP_DIAG || s_q.test_cnt == 7'(TEST_LEN_CYC - 1)) begin
            s_d.test = TEST_NONE;
         end
      end
      // Diag pin and firing checks
      if (s_q.op == OP_DIAG) begin
         s_d.arm_stuck = s_q.arm_stuck | STAT.arm_pin_stuck;
         s_d.fire_bad  = s_q.fire_bad | STAT.fire_time_bad;
      end
      // Overtemp latch: read clears, new event wins
      if (BUS.rd && BUS.addr == FAULT_STATUS_REG_ADDR) begin
         s_d.ot_latch  = 1'b0;
         s_d.rst_cause = 1'b0;
      end
      if (STAT.boost_overtemp) begin
         s_d.ot_latch = 1'b1;
      end
      // Read data
      s_d.rdata = 16'h0;
      if (BUS.rd) begin
         case (BUS.addr)
            SYSTEM_CONTROL_REG_ADDR: s_d.rdata = {13'h0, s_q.ctl};
            SYSTEM_CONFIG_REG_ADDR:  s_d.rdata = {15'h0, s_q.cfg};
            STATE_CMD_ADDR:          s_d.rdata = {11'h0, s_q.pm, s_q.op};
            TEST_CMD_ADDR:           s_d.rdata = {12'h0, s_q.fire_bad, s_q.arm_stuck, s_q.test};
            SAFING_RECORD_ADDR:      s_d.rdata = s_q.safing_rec;
            DEPLOY_MASK_ADDR:        s_d.rdata = s_q.deploy_mask;
            POWER_STATE_ADDR:        s_d.rdata = {15'h0, STAT.boost_undervolt};
            FAULT_STATUS_REG_ADDR:   s_d.rdata = {14'h0, s_q.rst_cause, s_q.ot_latch};
            WDG_WINDOW_ADDR:         s_d.rdata = {8'h0, s_q.wdg_win};
            default:                 s_d.rdata = 16'h0;
         endcase
      end
      // State machine reset wins over everything on the op path
      if (ssm_rst) begin
         s_d.op        = OP_INIT;
         s_d.test      = TEST_NONE;
         s_d.rst_cause = 1'b1;
      end
   end

   // State register
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         s_q <= '{op: OP_INIT, pm: PM_ACTIVE, ctl: CTL_RESET, cfg: CFG_RESET,
                  wdg_win: WDG_RESET, test: TEST_NONE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs
   always_comb begin
      CTL = '0;
      CTL.boost_high_sel       = s_q.ctl[CTL_BOOST_HI_BIT];
      CTL.boost_switch_on      = s_q.ctl[CTL_BOOST_EN_BIT] && !s_q.ot_latch &&
                                 !STAT.ground_lost && !STAT.battery_lost &&
                                 !(s_q.pm == PM_SLEEP) &&
                                 !(s_q.pm == PM_PASSIVE && !s_q.cfg);
      CTL.charge_gen_on        = active && s_q.ctl[CTL_CHARGE_EN_BIT];
      CTL.crossover_active_out = (s_q.pm == PM_PASSIVE);
      CTL.reserve_switch_on    = (s_q.pm == PM_PASSIVE);
      CTL.arm_out              = (s_q.op == OP_ARMING);
      CTL.safing_active        = (s_q.op == OP_SAFING);
      CTL.remote_monitor_on    = (s_q.op != OP_SCRAP && s_q.op != OP_ARMING);
      CTL.test_run             = s_q.test;
      CTL.sleep_req            = (s_q.pm == PM_SLEEP);
   end

   assign RDATA      = s_q.rdata;
   assign OP_STATE   = s_q.op;
   assign POWER_MODE = s_q.pm;

   // Assertions
   sequence s_safing_cmd;
      BUS.wr && BUS.addr == STATE_CMD_ADDR && cmd == CMD_SAFING;
   endsequence

   // Arming command as seen on the register port
   sequence s_arming_cmd;
      BUS.wr && BUS.addr == STATE_CMD_ADDR && cmd == CMD_ARMING;
   endsequence

   a_arm_out_state: assert property (@(posedge REF_CLK) disable iff (RST)
      (OP_STATE == OP_SCRAP && !ssm_rst) ##0 s_arming_cmd |=> CTL.arm_out && OP_STATE == OP_ARMING)
      else $error("arm output not raised");
   a_safing_entry: assert property (@(posedge REF_CLK) disable iff (RST)
      (OP_STATE == OP_DIAG && !ssm_rst) ##0 s_safing_cmd |=> OP_STATE == OP_SAFING)
      else $error("safing entry missed");
   a_safing_hold: assert property (@(posedge REF_CLK) disable iff (RST)
      OP_STATE == OP_SAFING && !ssm_rst |=> OP_STATE == OP_SAFING) else $error("safing left");
   a_reset_init: assert property (@(posedge REF_CLK) disable iff (RST)
      ssm_rst |=> OP_STATE == OP_INIT) else $error("reset not to init");
   a_scrap_exit: assert property (@(posedge REF_CLK) disable iff (RST)
      OP_STATE == OP_SCRAP && !ssm_rst |=> OP_STATE inside {OP_SCRAP, OP_ARMING})
      else $error("bad scrap exit");
   a_test_diag: assert property (@(posedge REF_CLK) disable iff (RST)
      $rose(CTL.test_run != TEST_NONE) |-> $past(OP_STATE) == OP_DIAG) else $error("test outside diag");
   a_charge_active: assert property (@(posedge REF_CLK) disable iff (RST)
      POWER_MODE != PM_ACTIVE |-> !CTL.charge_gen_on) else $error("charge outside active");
   a_passive_switch: assert property (@(posedge REF_CLK) disable iff (RST)
      POWER_MODE == PM_PASSIVE |-> CTL.crossover_active_out && CTL.reserve_switch_on)
      else $error("passive switches off");
   a_boost_passive: assert property (@(posedge REF_CLK) disable iff (RST)
      POWER_MODE == PM_PASSIVE && !s_q.cfg |-> !CTL.boost_switch_on) else $error("boost on in passive");
   a_supply_drop: assert property (@(posedge REF_CLK) disable iff (RST)
      POWER_MODE == PM_ACTIVE && STAT.supply_low |=> POWER_MODE == PM_PASSIVE)
      else $error("supply drop ignored");
   // A flag read in the cycle after the fault may legally release the switch
   a_ot_latch: assert property (@(posedge REF_CLK) disable iff (RST)
      STAT.boost_overtemp ##1 !(BUS.rd && BUS.addr == FAULT_STATUS_REG_ADDR)
      |-> !CTL.boost_switch_on ##1 !CTL.boost_switch_on)
      else $error("overtemp not latched");
endmodule

// >>> testbench/sscr_host_model.sv
/*
 Host controller model: drives one-cycle write and read strobes on the register port.
 Assumes a free-running clock and read data standing only in the cycle after the read.
*/
`timescale 1ns/10ps
module sscr_host_model (
   input  wire logic             clk,
   output sscr_pkg::sscr_bus_type bus,
   input  wire logic [15:0]      rdata
);
   import sscr_pkg::*;

   // Idle port from time zero
   initial bus = '0;

   // One-cycle write, signals change just after an edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // One-cycle read, data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      d = rdata;
   endtask
endmodule

// >>> testbench/tb_sscr_top.sv
/*
 Self-checking bench for the state and energy reserve control block.
 Assumes the host model for register access and short timing parameters.
*/
`timescale 1ns/10ps
module tb_sscr_top;
   import sscr_pkg::*;
   localparam int EW = 20;
   localparam int AT = 16;
   logic          ref_clk;
   logic          rst;
   sscr_bus_type  bus;
   logic [15:0]   rdata;
   sscr_stat_type stat;
   sscr_ctl_type  ctl;
   sscr_op_type   op_state;
   sscr_pm_type   power_mode;
   logic [15:0]   rv;
   int            fails;
   int            checks_done;

   // Design with shortened counts
   sscr_top #(.EARLY_WAKE_CYCLES(EW), .ARM_TIMEOUT_CYCLES(AT)) i_dut (.REF_CLK(ref_clk), .RST(rst),
      .BUS(bus), .RDATA(rdata), .STAT(stat), .CTL(ctl), .OP_STATE(op_state), .POWER_MODE(power_mode));
   sscr_host_model i_host (.clk(ref_clk), .bus(bus), .rdata(rdata));

   // 100 MHz clock
   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t %s: %h vs %h", $time, msg, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Step past n edges, settled
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Bounded wait for a state
   task automatic wait_op(input sscr_op_type s, input int lim);
      for (int i = 0; i < lim && op_state !== s; i++) cyc(1);
      if (op_state !== s) begin
         fails++;
         $display("[FAIL] %0t state wait ran out", $time);
         report_and_stop();
      end
   endtask

   // Reset held 20 cycles
   task automatic do_reset();
      @(posedge ref_clk);
      rst <= 1'b1;
      cyc(20);
      rst <= 1'b0;
      cyc(1);
   endtask

   // State or test command, then settle
   task automatic cmd(input logic [7:0] a, input logic [1:0] c);
      i_host.wr(a, {14'h0000, c});
      cyc(1);
   endtask

   // Watchdog service pulse
   task automatic to_diag();
      stat.wdg_service_ok <= 1'b1;
      cyc(1);
      stat.wdg_service_ok <= 1'b0;
      wait_op(OP_DIAG, 4);
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      stat = '0;
      stat.wake = 1'b1;
      fails = 0;
      checks_done = 0;
      do_reset();
      check(op_state, OP_INIT, "init");
      check(power_mode, PM_ACTIVE, "active");
      check({ctl.boost_switch_on, ctl.boost_high_sel, ctl.charge_gen_on}, 3'b100, "boost default");
      i_host.wr(WDG_WINDOW_ADDR, 16'h0055);
      i_host.wr(SAFING_RECORD_ADDR, 16'ha5a5);
      cmd(STATE_CMD_ADDR, CMD_SAFING);
      cmd(TEST_CMD_ADDR, TEST_HS_SW);
      check(op_state, OP_INIT, "cmd in init");
      check(ctl.test_run, TEST_NONE, "test in init");
      $display("test reset done");
      to_diag();
      i_host.rd(SAFING_RECORD_ADDR, rv);
      check(rv, 16'h0000, "record in init");
      i_host.wr(SAFING_RECORD_ADDR, 16'h1234);
      i_host.wr(DEPLOY_MASK_ADDR, 16'h3c3c);
      i_host.wr(WDG_WINDOW_ADDR, 16'h00aa);
      i_host.rd(SAFING_RECORD_ADDR, rv);
      check(rv, 16'h1234, "record");
      i_host.rd(DEPLOY_MASK_ADDR, rv);
      check(rv, 16'h3c3c, "mask");
      i_host.rd(WDG_WINDOW_ADDR, rv);
      check(rv, 16'h0055, "window");
      stat.arm_pin_stuck <= 1'b1;
      stat.fire_time_bad <= 1'b1;
      cmd(TEST_CMD_ADDR, TEST_HS_SW);
      cmd(TEST_CMD_ADDR, TEST_LS_SW);
      check(ctl.test_run, TEST_HS_SW, "second test");
      i_host.rd(TEST_CMD_ADDR, rv);
      check(rv[3:2], 2'b11, "stuck flag");
      cyc(1);
      check(rdata, 16'h0000, "rdata one cycle");
      stat.arm_pin_stuck <= 1'b0;
      stat.fire_time_bad <= 1'b0;
      cyc(TEST_LEN_CYC);
      check(ctl.test_run, TEST_NONE, "test end");
      cmd(STATE_CMD_ADDR, CMD_ARMING);
      check(op_state, OP_DIAG, "arming in diag");
      cmd(STATE_CMD_ADDR, CMD_SAFING);
      check({op_state, ctl.safing_active, ctl.remote_monitor_on}, {OP_SAFING, 2'b11}, "safing");
      cmd(STATE_CMD_ADDR, CMD_SCRAP);
      cmd(TEST_CMD_ADDR, TEST_SF_FET);
      check(op_state, OP_SAFING, "scrap in safing");
      check(ctl.test_run, TEST_NONE, "fet test");
      stat.wdg_fail <= 1'b1;
      cyc(1);
      stat.wdg_fail <= 1'b0;
      cyc(1);
      check(op_state, OP_INIT, "state reset");
      $display("test diag_safing done");
      to_diag();
      cmd(STATE_CMD_ADDR, CMD_SCRAP);
      check({op_state, ctl.safing_active, ctl.remote_monitor_on}, {OP_SCRAP, 2'b00}, "scrap");
      cmd(STATE_CMD_ADDR, CMD_SAFING);
      check(op_state, OP_SCRAP, "safing in scrap");
      cmd(STATE_CMD_ADDR, CMD_ARMING);
      check({op_state, ctl.arm_out}, {OP_ARMING, 1'b1}, "arming");
      cyc(AT - 4);
      check(op_state, OP_ARMING, "early exit");
      // Line check restarts the arming time-out
      stat.extra_line_check <= 1'b1;
      cyc(1);
      stat.extra_line_check <= 1'b0;
      cyc(AT - 1);
      check(op_state, OP_ARMING, "line check restart");
      wait_op(OP_SCRAP, 1);
      cmd(STATE_CMD_ADDR, CMD_ARMING);
      stat.wdg_reset <= 1'b1;
      cyc(1);
      stat.wdg_reset <= 1'b0;
      check({op_state, ctl.arm_out}, {OP_INIT, 1'b0}, "arming reset");
      to_diag();
      stat.por <= 1'b1;
      cyc(1);
      stat.por <= 1'b0;
      check(op_state, OP_INIT, "por reset");
      $display("test scrap_arming done");
      i_host.wr(SYSTEM_CONTROL_REG_ADDR, 16'h0007);
      cyc(1);
      check({ctl.boost_switch_on, ctl.boost_high_sel, ctl.charge_gen_on}, 3'b111, "ctl");
      stat.boost_undervolt <= 1'b1;
      i_host.rd(POWER_STATE_ADDR, rv);
      check(rv[0], 1'b1, "undervolt");
      stat.boost_undervolt <= 1'b0;
      i_host.rd(POWER_STATE_ADDR, rv);
      check(rv[0], 1'b0, "undervolt gone");
      stat.boost_overtemp <= 1'b1;
      cyc(1);
      stat.boost_overtemp <= 1'b0;
      cyc(5);
      check(ctl.boost_switch_on, 1'b0, "ot latch");
      i_host.rd(FAULT_STATUS_REG_ADDR, rv);
      check(rv[1:0], 2'b11, "ot flag");
      cyc(1);
      check(ctl.boost_switch_on, 1'b1, "ot released");
      i_host.rd(FAULT_STATUS_REG_ADDR, rv);
      check(rv[1:0], 2'b00, "fault cleared");
      stat.ground_lost <= 1'b1;
      cyc(1);
      check(ctl.boost_switch_on, 1'b0, "gnd lost");
      stat.ground_lost <= 1'b0;
      cyc(1);
      check(ctl.boost_switch_on, 1'b1, "gnd back");
      stat.battery_lost <= 1'b1;
      cyc(1);
      check(ctl.boost_switch_on, 1'b0, "bat lost");
      stat.battery_lost <= 1'b0;
      stat.supply_low <= 1'b1;
      cyc(2);
      check(power_mode, PM_PASSIVE, "supply drop");
      check({ctl.boost_switch_on, ctl.charge_gen_on}, 2'b00, "passive off");
      check({ctl.crossover_active_out, ctl.reserve_switch_on}, 2'b11, "crossover");
      stat.supply_low <= 1'b0;
      $display("test power done");
      do_reset();
      i_host.wr(SYSTEM_CONFIG_REG_ADDR, 16'h0001);
      cyc(2 * EW);
      i_host.wr(STATE_CMD_ADDR, 16'h8000);
      cyc(1);
      check(power_mode, PM_ACTIVE, "sleep with wake high");
      stat.wake <= 1'b0;
      cyc(3);
      check(power_mode, PM_ACTIVE, "late wake");
      i_host.wr(STATE_CMD_ADDR, 16'h8000);
      cyc(1);
      check({power_mode, ctl.boost_switch_on}, {PM_PASSIVE, 1'b1}, "confirm");
      $display("test late_sleep done");
      stat.wake <= 1'b1;
      do_reset();
      stat.wake <= 1'b0;
      cyc(3);
      check({power_mode, ctl.sleep_req}, {PM_SLEEP, 1'b1}, "early wake");
      $display("test early_sleep done");
      report_and_stop();
   end
endmodule
